//--- hdl/dcc_pkg.sv
// Constants and types for the converter channel control block.
// Assumes a 40 MHz system clock and a 32-bit AXI4-Lite register bus.
package dcc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int CAL_TIME_NS = 5000;
  localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTL = 8'h00;
  localparam logic [7:0] ADDR_DAT = 8'h04;
  localparam logic [7:0] ADDR_ISTAT = 8'h08;
  localparam logic [7:0] ADDR_IMASK = 8'h0c;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int GRP_BIT = 0;
  localparam int ENC_BIT = 1;
  localparam int IFG_BIT = 2;
  localparam int IE_BIT = 3;
  localparam int DF_BIT = 4;
  localparam int AMP_LSB = 5;
  localparam int IR_BIT = 8;
  localparam int CAL_BIT = 9;
  localparam int LSEL_LSB = 10;
  localparam int RES_BIT = 12;
  localparam int SREF_LSB = 13;

  // Writable control bits, and those frozen while conversion is enabled
  localparam logic [15:0] CTL_RW_MASK = 16'h7dff;
  localparam logic [15:0] CTL_LOCK_MASK = 16'h7df0;
  localparam logic [15:0] CTL_RESET = 16'h0000;
  localparam logic [11:0] DAT_RESET = 12'h000;

  // ----------------------------------------------------------------
  // Interrupt status bits
  // ----------------------------------------------------------------
  localparam int EV_LATCH = 0;
  localparam int EV_CAL = 1;
  localparam int EV_W = 2;
  localparam logic [1:0] EV_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [2:0] AMP_OFF_HIZ = 3'h0;
  localparam logic [2:0] AMP_OFF_ZERO = 3'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    LSEL_WRITE = 2'b00,
    LSEL_GROUP = 2'b01,
    LSEL_TIMER1 = 2'b10,
    LSEL_TIMER2 = 2'b11
  } dcc_lsel_t;

  typedef enum logic {
    CAL_IDLE = 1'b0,
    CAL_RUN = 1'b1
  } dcc_cal_state_t;

endpackage

//--- hdl/dcc_pin_rise.sv
// Pin synchroniser with rising-edge pulse for the timer trigger inputs.
// Assumes the pin is asynchronous to sys_clk_i.
`timescale 1ns/1ps

module dcc_pin_rise (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic rise_o
);

  logic s1;
  logic s2;
  logic s3;
  logic level;

  // Three stage chain; only the second stage reads the first
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Level accepted once stages two and three agree; filters a one-cycle blip
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      level <= 1'b0;
      rise_o <= 1'b0;
    end else begin
      rise_o <= 1'b0;
      if (s2 == s3) begin
        level <= s3;
        rise_o <= s3 & ~level;
      end
    end
  end

endmodule

//--- hdl/dcc_channel.sv
// Control and data registers for one 12-bit converter channel.
// Assumes AXI4-Lite from a master on sys_clk_i, timer outputs as raw pins,
// and a same-clock write pulse from the next higher channel for grouping.
`timescale 1ns/1ps

// Function
// R1 - Reference field codes 00/01 pick internal, 10/11 external reference.
// R2 - Load code 00 latches on every data write, enable ignored.
// R3 - Code 01 latches per write, or after all grouped channels written.
// R4 - Code 10 latches on rising edge of first timer output.
// R5 - Code 11 latches on rising edge of second timer output.
// R6 - Nonzero load code latches only while conversion enable is set.
// R7 - Writing calibration bit starts calibration; reads one until done, self-clears.
// R8 - Amplifier 000 off high-Z, 001 off driving zero, others speeds.
// R9 - Group bit joins next higher channel; unused on highest channel.
// R10 - Data bits 15-12 read zero and never reach the core.
// R11 - 12-bit mode right-justified, bit 11 is MSB or sign.
// R12 - 8-bit mode uses bits 7-0, bits 11-8 ignored.
// R13 - Latch with nonzero load code sets interrupt flag; code zero never.
// R14 - Interrupt while flag and enable set; flag cleared only by software.
// R15 - Bit 12 picks 12/8-bit; bit 4 picks binary/two's complement.
// R16 - Two's complement converts by inverting the selected sign bit.
module dcc_channel #(
  parameter int ADDR_W = 8,
  parameter bit IS_HIGHEST_CHANNEL = 1'b0,
  parameter int CAL_CYCLES = dcc_pkg::CAL_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic first_timer_output1_i,
  input wire logic second_timer_output2_i,
  input wire logic peer_data_written_i,
  output logic data_written_o,
  output logic [11:0] core_code_o,
  output logic ref_external_o,
  output logic resolution_select_o,
  output logic input_range_select_o,
  output logic [2:0] amplifier_setting_o,
  output logic output_hiz_o,
  output logic output_zero_o,
  output logic cal_active_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Decode to {miss, index}; only low byte of address is compared
  function automatic logic [2:0] reg_decode(input logic [ADDR_W-1:0] a);
    logic [7:0] b;
    b = a[7:0];
    if (b == dcc_pkg::ADDR_CTL) reg_decode = 3'h0;
    else if (b == dcc_pkg::ADDR_DAT) reg_decode = 3'h1;
    else if (b == dcc_pkg::ADDR_ISTAT) reg_decode = 3'h2;
    else if (b == dcc_pkg::ADDR_IMASK) reg_decode = 3'h3;
    else reg_decode = 3'h4;
  endfunction

  // Byte-lane merge for the 16-bit registers
  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [15:0] d,
                                             input logic [1:0] strb);
    lane_merge = old;
    if (strb[0]) lane_merge[7:0] = d[7:0];
    if (strb[1]) lane_merge[15:8] = d[15:8];
  endfunction

  // Data word to core code
  function automatic logic [11:0] core_conv(input logic [11:0] d,
                                            input logic res8,
                                            input logic twos);
    // R16 sign flip
    if (res8) core_conv = {d[7] ^ twos, d[6:0], 4'h0};
    else core_conv = {d[11] ^ twos, d[10:0]};
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] waddr;
  logic aw_full;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic w_full;
  logic wr_fire;
  logic [2:0] wsel;
  logic [15:0] ctl;
  logic [11:0] dat;
  logic [15:0] dat_merge;
  logic [dcc_pkg::EV_W-1:0] istat;
  logic [dcc_pkg::EV_W-1:0] imask;
  logic dat_we;
  logic wr_evt;
  logic own_seen;
  logic peer_seen;
  logic grouped;
  logic load;
  logic cal_start;
  logic cal_done;
  logic [15:0] cal_cnt;
  logic t1_rise;
  logic t2_rise;
  logic rd_is_dat;
  logic [15:0] ctl_view;
  logic [15:0] next_ctl;
  dcc_pkg::dcc_lsel_t lsel;
  dcc_pkg::dcc_cal_state_t cal_state;

  assign lsel = dcc_pkg::dcc_lsel_t'(ctl[dcc_pkg::LSEL_LSB +: 2]);
  // R9 group bit
  assign grouped = ctl[dcc_pkg::GRP_BIT] & ~IS_HIGHEST_CHANNEL;
  assign ctl_view = ctl | {6'h00, (cal_state == dcc_pkg::CAL_RUN), 9'h000};
  assign wsel = reg_decode(waddr);
  assign wr_fire = aw_full & w_full & ~s_axi_bvalid_o;
  assign dat_we = wr_fire & (wsel == 3'h1);
  assign cal_start = wr_fire & (wsel == 3'h0) & wstrb[1]
                     & wdata[dcc_pkg::CAL_BIT] & (cal_state == dcc_pkg::CAL_IDLE);

  // ----------------------------------------------------------------
  // Timer pin inputs
  // ----------------------------------------------------------------
  dcc_pin_rise u_tmr1 (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .pin_i(first_timer_output1_i),
    .rise_o(t1_rise)
  );

  dcc_pin_rise u_tmr2 (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .pin_i(second_timer_output2_i),
    .rise_o(t2_rise)
  );

  // ----------------------------------------------------------------
  // AXI write channels
  // ----------------------------------------------------------------
  // Address and data held independently; ready drops until response taken
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_axi_awready_o <= 1'b1;
      aw_full <= 1'b0;
      waddr <= '0;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      s_axi_awready_o <= 1'b0;
      aw_full <= 1'b1;
      waddr <= s_axi_awaddr_i;
    end else if (s_axi_bvalid_o && s_axi_bready_i) begin
      s_axi_awready_o <= 1'b1;
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_axi_wready_o <= 1'b1;
      w_full <= 1'b0;
      wdata <= 32'h0000_0000;
      wstrb <= 4'h0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      s_axi_wready_o <= 1'b0;
      w_full <= 1'b1;
      wdata <= s_axi_wdata_i;
      wstrb <= s_axi_wstrb_i;
    end else if (s_axi_bvalid_o && s_axi_bready_i) begin
      s_axi_wready_o <= 1'b1;
      w_full <= 1'b0;
    end
  end

  // Write response one cycle after both halves are held
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= dcc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= wsel[2] ? dcc_pkg::RESP_SLVERR : dcc_pkg::RESP_OKAY;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AXI read channel
  // ----------------------------------------------------------------
  // Reads have no side effects; answer one cycle after the address
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= dcc_pkg::RESP_OKAY;
      rd_is_dat <= 1'b0;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= dcc_pkg::RESP_OKAY;
      rd_is_dat <= 1'b0;
      unique case (reg_decode(s_axi_araddr_i))
        3'h0: s_axi_rdata_o <= {16'h0000, ctl_view};
        3'h1: begin
          // R10 upper nibble zero
          s_axi_rdata_o <= {20'h0_0000, dat};
          rd_is_dat <= 1'b1;
        end
        3'h2: s_axi_rdata_o <= {30'h0000_0000, istat};
        3'h3: s_axi_rdata_o <= {30'h0000_0000, imask};
        default: begin
          s_axi_rdata_o <= 32'h0000_0000;
          s_axi_rresp_o <= dcc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Software value, with configuration frozen while conversion is enabled
  always_comb begin
    next_ctl = lane_merge(ctl, wdata[15:0], wstrb[1:0]) & dcc_pkg::CTL_RW_MASK;
    if (ctl[dcc_pkg::ENC_BIT]) begin
      next_ctl = (ctl & dcc_pkg::CTL_LOCK_MASK) | (next_ctl & ~dcc_pkg::CTL_LOCK_MASK);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctl <= dcc_pkg::CTL_RESET;
    end else begin
      if (wr_fire && wsel == 3'h0) begin
        ctl <= next_ctl;
      end
      // R13 flag set, wins over a software clear
      if (load && lsel != dcc_pkg::LSEL_WRITE) begin
        ctl[dcc_pkg::IFG_BIT] <= 1'b1;
      end
    end
  end

  // Merged data word; a function result cannot be sliced in place
  assign dat_merge = lane_merge({4'h0, dat}, wdata[15:0], wstrb[1:0]);

  // Data register, 12 bits kept
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      dat <= dcc_pkg::DAT_RESET;
      wr_evt <= 1'b0;
      data_written_o <= 1'b0;
    end else begin
      wr_evt <= dat_we;
      data_written_o <= dat_we;
      if (dat_we) begin
        dat <= dat_merge[11:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Load trigger
  // ----------------------------------------------------------------
  always_comb begin
    unique case (lsel)
      // R2 write load, enable ignored
      dcc_pkg::LSEL_WRITE: load = wr_evt;
      // R3 grouped waits for every member; R6 enable gate
      dcc_pkg::LSEL_GROUP: load = ctl[dcc_pkg::ENC_BIT] & (grouped ?
        ((own_seen | wr_evt) & (peer_seen | peer_data_written_i)) : wr_evt);
      // R4 first timer edge
      dcc_pkg::LSEL_TIMER1: load = ctl[dcc_pkg::ENC_BIT] & t1_rise;
      // R5 second timer edge
      dcc_pkg::LSEL_TIMER2: load = ctl[dcc_pkg::ENC_BIT] & t2_rise;
    endcase
  end

  // R3 group bookkeeping; both seen flags clear in the load cycle, so a write then is not kept for next round
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !grouped) begin
      own_seen <= 1'b0;
      peer_seen <= 1'b0;
    end else if (load) begin
      own_seen <= 1'b0;
      peer_seen <= 1'b0;
    end else begin
      own_seen <= own_seen | wr_evt;
      peer_seen <= peer_seen | peer_data_written_i;
    end
  end

  // Conversion latch; R11 R12 R15 alignment and format
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      core_code_o <= 12'h000;
    end else if (load) begin
      core_code_o <= core_conv(dat, ctl[dcc_pkg::RES_BIT], ctl[dcc_pkg::DF_BIT]);
    end
  end

  // ----------------------------------------------------------------
  // Analog control outputs
  // ----------------------------------------------------------------
  // R1 reference route; R8 amplifier power codes
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ref_external_o <= 1'b0;
      resolution_select_o <= 1'b0;
      input_range_select_o <= 1'b0;
      amplifier_setting_o <= dcc_pkg::AMP_OFF_HIZ;
      output_hiz_o <= 1'b1;
      output_zero_o <= 1'b0;
    end else begin
      ref_external_o <= ctl[dcc_pkg::SREF_LSB + 1];
      resolution_select_o <= ctl[dcc_pkg::RES_BIT];
      input_range_select_o <= ctl[dcc_pkg::IR_BIT];
      amplifier_setting_o <= ctl[dcc_pkg::AMP_LSB +: 3];
      output_hiz_o <= ctl[dcc_pkg::AMP_LSB +: 3] == dcc_pkg::AMP_OFF_HIZ;
      output_zero_o <= ctl[dcc_pkg::AMP_LSB +: 3] == dcc_pkg::AMP_OFF_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Calibration
  // ----------------------------------------------------------------
  // R7 fixed-length run; writing zero does not abort it
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cal_state <= dcc_pkg::CAL_IDLE;
      cal_cnt <= 16'h0000;
      cal_active_o <= 1'b0;
    end else begin
      unique case (cal_state)
        dcc_pkg::CAL_IDLE: begin
          if (cal_start) begin
            cal_state <= dcc_pkg::CAL_RUN;
            cal_cnt <= 16'(CAL_CYCLES - 1);
            cal_active_o <= 1'b1;
          end
        end
        dcc_pkg::CAL_RUN: begin
          if (cal_done) begin
            cal_state <= dcc_pkg::CAL_IDLE;
            cal_active_o <= 1'b0;
          end else begin
            cal_cnt <= cal_cnt - 16'h0001;
          end
        end
      endcase
    end
  end
  assign cal_done = (cal_state == dcc_pkg::CAL_RUN) && (cal_cnt == 16'h0000);

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      istat <= dcc_pkg::EV_RESET;
      imask <= dcc_pkg::EV_RESET;
    end else begin
      if (wr_fire && wsel == 3'h2 && wstrb[0]) begin
        istat <= istat & ~wdata[dcc_pkg::EV_W-1:0];
      end
      if (wr_fire && wsel == 3'h3 && wstrb[0]) begin
        imask <= wdata[dcc_pkg::EV_W-1:0];
      end
      if (load && lsel != dcc_pkg::LSEL_WRITE) begin
        istat[dcc_pkg::EV_LATCH] <= 1'b1;
      end
      if (cal_done) begin
        istat[dcc_pkg::EV_CAL] <= 1'b1;
      end
    end
  end

  // R14 request while flag and enable both set
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= (ctl[dcc_pkg::IFG_BIT] & ctl[dcc_pkg::IE_BIT]) | (|(istat & imask));
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  localparam int CAL_WAIT = 1000;

  sequence s_cal_begin;
    cal_start ##1 ctl_view[dcc_pkg::CAL_BIT];
  endsequence

  sequence s_cal_hold;
    ctl_view[dcc_pkg::CAL_BIT] [*8];
  endsequence

  a_ref_route: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R1
    $changed(ctl[dcc_pkg::SREF_LSB + 1]) |=> ref_external_o == $past(ctl[14]))
    else $error("reference route mismatch");

  a_write_load: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R2
    dat_we && lsel == dcc_pkg::LSEL_WRITE && !(wr_fire && wsel == 3'h0) |=> load)
    else $error("write load missing");

  a_group_wait: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R3
    load && grouped && lsel == dcc_pkg::LSEL_GROUP |->
    (own_seen || wr_evt) && (peer_seen || peer_data_written_i))
    else $error("group loaded early");

  a_timer1_load: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R4
    t1_rise && lsel == dcc_pkg::LSEL_TIMER1 && ctl[dcc_pkg::ENC_BIT] |-> load)
    else $error("timer one load missing");

  a_timer2_load: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R5
    t2_rise && lsel == dcc_pkg::LSEL_TIMER2 && ctl[dcc_pkg::ENC_BIT] |-> load)
    else $error("timer two load missing");

  a_enable_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R6
    load && lsel != dcc_pkg::LSEL_WRITE |-> ctl[dcc_pkg::ENC_BIT])
    else $error("load while disabled");

  a_cal_run: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R7
    s_cal_begin |-> s_cal_hold ##[1:CAL_WAIT] !ctl_view[dcc_pkg::CAL_BIT])
    else $error("calibration bit timing wrong");

  a_amp_hiz: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R8
    ctl[7:5] == dcc_pkg::AMP_OFF_HIZ |=> output_hiz_o && !output_zero_o)
    else $error("amplifier off code not honoured");

  a_dat_upper: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R10
    s_axi_rvalid_o && rd_is_dat |-> s_axi_rdata_o[15:12] == 4'h0)
    else $error("data upper bits not zero");

  a_code_binary: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R11
    load && !ctl[dcc_pkg::RES_BIT] && !ctl[dcc_pkg::DF_BIT] |=> core_code_o == $past(dat))
    else $error("binary code mismatch");

  a_flag_set: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R13
    load && lsel != dcc_pkg::LSEL_WRITE |=> ctl[dcc_pkg::IFG_BIT])
    else $error("interrupt flag not set");

  a_irq_level: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R14
    ctl[dcc_pkg::IFG_BIT] && ctl[dcc_pkg::IE_BIT] |=> irq_o)
    else $error("interrupt request missing");

endmodule

//--- dv/dcc_channel_tb.sv
// Self-checking bench for one converter channel's control and data registers.
// Assumes the design's own in-file assertions; drives AXI4-Lite, timer pins, peer pulse.
`timescale 1ns/1ps

`define CHK(nm, exp, got) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("Error %s expected %h seen %h", nm, exp, got); \
  end \
end

module dcc_channel_tb;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic tmr1 = 1'b0, tmr2 = 1'b0, peer = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, dw, ref_ext, res_sel, ir_sel;
  logic hiz, zero, cal, irq;
  logic [1:0] bresp, rresp, rs, wb;
  logic [11:0] code;
  logic [2:0] amp;
  int n_errors = 0;
  int checks_done = 0;
  int dw_cnt = 0;
  int n0;

  // Short simulated calibration so the run stays brief
  dcc_channel #(.CAL_CYCLES(10)) dut (
    .sys_clk_i(sys_clk), .rst_i(rst), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .first_timer_output1_i(tmr1), .second_timer_output2_i(tmr2),
    .peer_data_written_i(peer), .data_written_o(dw), .core_code_o(code),
    .ref_external_o(ref_ext), .resolution_select_o(res_sel), .input_range_select_o(ir_sel),
    .amplifier_setting_o(amp), .output_hiz_o(hiz), .output_zero_o(zero),
    .cal_active_o(cal), .irq_o(irq));

  // Clock and write-pulse counter
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (dw === 1'b1) dw_cnt++;

  // ------------------------------------------------------------
  // Bus and pin tasks
  // ------------------------------------------------------------
  // Each channel released at its own handshake; response waited on a bound
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (n < 100) begin
      @(posedge sys_clk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    wb = bresp;
    bready <= 1'b0;
    if (n >= 100) n_errors++;
  endtask

  task automatic rdr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n < 100) begin
      @(posedge sys_clk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (n >= 100) n_errors++;
  endtask

  // Held several cycles since the pins pass a three-flop synchroniser
  task automatic pulse(input int which);
    @(posedge sys_clk);
    if (which == 1) tmr1 <= 1'b1;
    else tmr2 <= 1'b1;
    repeat (4) @(posedge sys_clk);
    tmr1 <= 1'b0;
    tmr2 <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic wd(input logic [31:0] d);
    wr(dcc_pkg::ADDR_DAT, d);
    repeat (3) @(posedge sys_clk);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_load_fmt;
    rdr(8'h10);
    `CHK("unmapped resp", dcc_pkg::RESP_SLVERR, rs)
    wr(8'h10, 32'h0000ffff);
    `CHK("unmapped wresp", dcc_pkg::RESP_SLVERR, wb)
    `CHK("hiz at reset", 1'b1, hiz)
    n0 = dw_cnt;
    wd(32'h0000fabc);
    `CHK("code write", 12'habc, code)
    `CHK("data wresp", dcc_pkg::RESP_OKAY, wb)
    `CHK("write pulses", n0 + 1, dw_cnt)
    rdr(dcc_pkg::ADDR_DAT);
    `CHK("data upper", 32'h00000abc, rd)
    rdr(dcc_pkg::ADDR_CTL);
    `CHK("flag code0", 1'b0, rd[2])
    wr(dcc_pkg::ADDR_CTL, 32'h0010);
    wd(32'h0800);
    `CHK("code 12b twos", 12'h000, code)
    wr(dcc_pkg::ADDR_CTL, 32'h1000);
    wd(32'h0f5a);
    `CHK("code 8b bin", 12'h5a0, code)
    `CHK("res sel", 1'b1, res_sel)
    wr(dcc_pkg::ADDR_CTL, 32'h1010);
    wd(32'h0f80);
    `CHK("code 8b twos", 12'h000, code)
    $display("load and format test done");
  endtask

  task automatic t_timer;
    wr(dcc_pkg::ADDR_CTL, 32'h0808);
    wd(32'h0123);
    pulse(1);
    `CHK("no enable", 12'h000, code)
    wr(dcc_pkg::ADDR_CTL, 32'h080a);
    pulse(1);
    `CHK("timer1 code", 12'h123, code)
    rdr(dcc_pkg::ADDR_CTL);
    `CHK("flag set", 1'b1, rd[2])
    `CHK("irq set", 1'b1, irq)
    wr(dcc_pkg::ADDR_CTL, 32'h080a);
    repeat (3) @(posedge sys_clk);
    `CHK("irq cleared", 1'b0, irq)
    wr(dcc_pkg::ADDR_CTL, 32'h0000);
    wr(dcc_pkg::ADDR_CTL, 32'h0c0a);
    wd(32'h0456);
    pulse(1);
    `CHK("timer1 ignored", 12'h123, code)
    pulse(2);
    `CHK("timer2 code", 12'h456, code)
    $display("timer test done");
  endtask

  task automatic t_group;
    wr(dcc_pkg::ADDR_CTL, 32'h0000);
    wr(dcc_pkg::ADDR_CTL, 32'h0403);
    wd(32'h0321);
    repeat (2) @(posedge sys_clk);
    `CHK("group wait", 12'h456, code)
    @(posedge sys_clk);
    peer <= 1'b1;
    @(posedge sys_clk);
    peer <= 1'b0;
    repeat (3) @(posedge sys_clk);
    `CHK("group latch", 12'h321, code)
    wr(dcc_pkg::ADDR_CTL, 32'h0402);
    wd(32'h0654);
    `CHK("ungrouped", 12'h654, code)
    $display("group test done");
  endtask

  task automatic t_cal_amp;
    wr(dcc_pkg::ADDR_CTL, 32'h0000);
    wr(dcc_pkg::ADDR_IMASK, 32'h2);
    wr(dcc_pkg::ADDR_CTL, 32'h0200);
    `CHK("cal active", 1'b1, cal)
    rdr(dcc_pkg::ADDR_CTL);
    `CHK("cal bit", 1'b1, rd[9])
    repeat (12) @(posedge sys_clk);
    rdr(dcc_pkg::ADDR_CTL);
    `CHK("cal clears", 1'b0, rd[9])
    `CHK("cal irq", 1'b1, irq)
    wr(dcc_pkg::ADDR_ISTAT, 32'h3);
    repeat (2) @(posedge sys_clk);
    `CHK("status w1c", 1'b0, irq)
    wr(dcc_pkg::ADDR_CTL, 32'h4120);
    repeat (2) @(posedge sys_clk);
    `CHK("ref ext", 1'b1, ref_ext)
    `CHK("range sel", 1'b1, ir_sel)
    `CHK("out zero", 2'b01, {hiz, zero})
    wr(dcc_pkg::ADDR_CTL, 32'h20c0);
    repeat (2) @(posedge sys_clk);
    `CHK("ref int", 1'b0, ref_ext)
    `CHK("range clr", 1'b0, ir_sel)
    `CHK("amp fast", 5'h18, {amp, hiz, zero})
    $display("calibration and amplifier test done");
  endtask

  // ------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Tests take about 240 cycles; the limit leaves wide margin
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    conclude();
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_load_fmt();
    t_timer();
    t_group();
    t_cal_amp();
    conclude();
  end
endmodule
